// *** rtl/fault_delay.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pol_regs.svh"

module fault_delay (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // condition in, qualified level out
    input wire logic cond,
    output logic level
);
    localparam int unsigned DELAY = `FAULT_DELAY_CYC;

    logic [7:0] count;

    // the level follows cond only after cond has differed for DELAY cycles
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count <= 8'h00;
            level <= 1'b0;
        end else if (cond == level) begin
            count <= 8'h00;
        end else if (count == 8'(DELAY - 1)) begin
            count <= 8'h00;
            level <= cond;
        end else begin
            count <= count + 8'h01;
        end
    end

    AST_DELAY_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (level != $past(level)) |-> ($past(count) == 8'(DELAY - 1)) && ($past(cond) == level))
        else $error("qualified level changed before the delay ran out");
endmodule : fault_delay
`default_nettype wire

// *** rtl/hiccup_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

module hiccup_timer #(
    parameter int unsigned PERIOD = 1300000
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // run while a non-latched channel is off, done pulses each period
    input wire logic run,
    output logic done
);
    logic [31:0] count;

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run) begin
            count <= 32'h00000000;
            done <= 1'b0;
        end else if (count == PERIOD - 1) begin
            count <= 32'h00000000;
            done <= 1'b1;
        end else begin
            count <= count + 32'h00000001;
            done <= 1'b0;
        end
    end
endmodule : hiccup_timer
`default_nettype wire

// *** rtl/pol_fault_protection_monitor.sv ***
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pol_regs.svh"

module pol_fault_protection_monitor #(
    parameter int unsigned RETRY_CYCLES = `RETRY_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // sensed quantities from the controller's converters
    input wire pol_pkg::millivolt_type vout_mv,
    input wire pol_pkg::millivolt_type vref_mv,
    input wire pol_pkg::milliamp_type iout_ma,
    input wire pol_pkg::celsius_type temp_c,
    // power stage state
    input wire logic ramp_active,
    input wire logic output_on,
    // protection outputs
    output logic turn_off,
    output logic power_good_output,
    output logic ot_warning
);
    import pol_pkg::*;

    localparam int NCH = int'(CH_COUNT);
    localparam int NQ = int'(QU_COUNT);

    // configuration
    logic [3:0] oc_code;
    logic [1:0] ov_code;
    logic [1:0] uv_code;
    logic pg_code;
    logic [NCH-1:0] latch_mode;
    logic trk_en;
    millivolt_type vset;

    // bus state
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] next_rdata;
    logic [NCH-1:0] clear_req;

    // protection state
    logic [NCH-1:0] tripped;
    logic [NCH-1:0] fault_set;
    logic [NCH-1:0] retry_done;
    logic [NQ-1:0] qcond;
    logic [NQ-1:0] qlvl;

    // derived thresholds and scaled values
    logic [7:0] oc_pct;
    logic [7:0] ov_pct;
    logic [7:0] uv_pct;
    logic [7:0] pg_lo_pct;
    logic [31:0] vout_x100;
    logic [31:0] iout_x100;
    logic [13:0] trk_err;
    logic oc_hit;
    logic ov_hit;
    logic uv_hit;
    logic trk_hit;
    logic in_window;

    // ---------------- bus slave ----------------
    // zero wait state, every access answered OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= hsel && htrans[1] && hready && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // read data is fetched in the address phase and stands through the data phase
    always_comb begin
        next_rdata = 32'h00000000;
        if (haddr[7:0] == `CTRL_ADDR) begin
            next_rdata[`CTRL_OC_LSB +: 4] = oc_code;
            next_rdata[`CTRL_OV_LSB +: 2] = ov_code;
            next_rdata[`CTRL_UV_LSB +: 2] = uv_code;
            next_rdata[`CTRL_PG_BIT] = pg_code;
            next_rdata[`CTRL_LATCH_LSB +: NCH] = latch_mode;
            next_rdata[`CTRL_TRK_BIT] = trk_en;
        end else if (haddr[7:0] == `SETPOINT_ADDR) begin
            next_rdata[12:0] = vset;
        end else if (haddr[7:0] == `STATUS_ADDR) begin
            next_rdata[NCH-1:0] = tripped;
            next_rdata[5] = ot_warning;
            next_rdata[6] = power_good_output;
            next_rdata[7] = turn_off;
            next_rdata[8 +: NQ] = qlvl;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hrdata <= 32'h00000000;
        end else if (hsel && htrans[1] && hready && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // out-of-range codes are clamped so the threshold stays within its span
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            oc_code <= `OC_CODE_RST;
            ov_code <= `OV_CODE_RST;
            uv_code <= `UV_CODE_RST;
            pg_code <= `PG_CODE_RST;
            latch_mode <= `LATCH_RST;
            trk_en <= `TRK_EN_RST;
        end else if (wr_pend && wr_addr == `CTRL_ADDR) begin
            oc_code <= (hwdata[`CTRL_OC_LSB +: 4] > `OC_MAX_CODE) ? `OC_MAX_CODE
                       : hwdata[`CTRL_OC_LSB +: 4];
            ov_code <= (hwdata[`CTRL_OV_LSB +: 2] > `OV_MAX_CODE) ? `OV_MAX_CODE
                       : hwdata[`CTRL_OV_LSB +: 2];
            uv_code <= (hwdata[`CTRL_UV_LSB +: 2] > `UV_MAX_CODE) ? `UV_MAX_CODE
                       : hwdata[`CTRL_UV_LSB +: 2];
            pg_code <= hwdata[`CTRL_PG_BIT];
            latch_mode <= hwdata[`CTRL_LATCH_LSB +: NCH];
            trk_en <= hwdata[`CTRL_TRK_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vset <= `VSET_RST;
        end else if (wr_pend && wr_addr == `SETPOINT_ADDR) begin
            vset <= hwdata[12:0];
        end
    end

    // one-cycle request to release latched channels
    always_comb begin
        clear_req = '0;
        if (wr_pend && wr_addr == `CLEAR_ADDR) begin
            clear_req = hwdata[NCH-1:0];
        end
    end

    // ---------------- thresholds ----------------
    assign oc_pct = `OC_BASE_PCT + 8'(`OC_STEP_PCT * oc_code);
    assign ov_pct = `OV_BASE_PCT + 8'(`OV_STEP_PCT * ov_code);
    assign uv_pct = `UV_BASE_PCT + 8'(`UV_STEP_PCT * uv_code);
    assign pg_lo_pct = `PG_LO_BASE_PCT + (pg_code ? `PG_LO_STEP_PCT : 8'h00);
    assign vout_x100 = {19'h00000, vout_mv} * 32'h00000064;
    assign iout_x100 = {16'h0000, iout_ma} * 32'h00000064;
    assign trk_err = (vout_mv > vref_mv) ? {1'b0, vout_mv - vref_mv}
                                         : {1'b0, vref_mv - vout_mv};

    // overcurrent acts on the raw comparison, no qualifier delay is given for it
    assign oc_hit = iout_x100 > `RATED_MA * {24'h000000, oc_pct};
    // effective trip level is the larger of the percentage and the floor
    assign ov_hit = (vout_x100 > {19'h00000, vset} * {24'h000000, ov_pct})
                    && (vout_mv > `OV_FLOOR_MV);
    // undervoltage only means something once the output has finished ramping
    assign uv_hit = output_on && !ramp_active
                    && (vout_x100 < {19'h00000, vset} * {24'h000000, uv_pct});
    assign trk_hit = trk_en && ramp_active && (trk_err > `TRK_LIMIT_MV);
    assign in_window = (vout_x100 >= {19'h00000, vset} * {24'h000000, pg_lo_pct})
                       && (vout_x100 <= {19'h00000, vset} * {24'h000000, `PG_HI_PCT});

    // hysteresis is chosen by the qualified level, so the band edge moves with it
    always_comb begin
        qcond = '0;
        qcond[QU_OV] = ov_hit;
        qcond[QU_UV] = uv_hit;
        qcond[QU_OT] = qlvl[QU_OT] ? (temp_c > $signed(`OT_REARM_C))
                                   : (temp_c >= $signed(`OT_TRIP_C));
        qcond[QU_TRK] = trk_hit;
        qcond[QU_WARN] = qlvl[QU_WARN] ? (temp_c > $signed(`WARN_C - `WARN_HYST_C))
                                       : (temp_c >= $signed(`WARN_C));
        qcond[QU_PG] = in_window;
    end

    // each condition waits out the same 6 us before it is believed
    for (genvar q = 0; q < NQ; q++) begin : g_qual
        fault_delay u_delay (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .cond(qcond[q]),
            .level(qlvl[q])
        );
    end

    // ---------------- fault channels ----------------
    assign fault_set[CH_OC] = oc_hit;
    assign fault_set[CH_OV] = qlvl[QU_OV];
    assign fault_set[CH_UV] = qlvl[QU_UV];
    assign fault_set[CH_OT] = qlvl[QU_OT];
    assign fault_set[CH_TRK] = qlvl[QU_TRK];

    // a fault that is present in the clearing cycle keeps the channel off
    for (genvar c = 0; c < NCH; c++) begin : g_chan
        hiccup_timer #(
            .PERIOD(RETRY_CYCLES)
        ) u_retry (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .run(tripped[c] && !latch_mode[c]),
            .done(retry_done[c])
        );

        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                tripped[c] <= 1'b0;
            end else if (fault_set[c]) begin
                tripped[c] <= 1'b1;
            end else if (latch_mode[c] ? clear_req[c] : retry_done[c]) begin
                tripped[c] <= 1'b0;
            end
        end
    end

    // ---------------- outputs ----------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            turn_off <= 1'b0;
            power_good_output <= 1'b0;
            ot_warning <= 1'b0;
        end else begin
            turn_off <= |tripped;
            power_good_output <= qlvl[QU_PG];
            ot_warning <= qlvl[QU_WARN];
        end
    end

    // ---------------- checks ----------------
    AST_OC_SPAN: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (oc_pct >= `OC_BASE_PCT) && (oc_pct <= 8'hAA) && (oc_code <= `OC_MAX_CODE))
        else $error("overcurrent threshold outside its span");

    AST_OV_DEFAULT: assert property (@(posedge sys_clk)
        $past(!rst_n) |-> (ov_pct == 8'h82))
        else $error("overvoltage threshold not at its default after reset");

    AST_OV_FLOOR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(qlvl[QU_OV]) |-> $past(vout_mv, 2) > `OV_FLOOR_MV)
        else $error("overvoltage tripped below one volt");

    AST_UV_DEFAULT: assert property (@(posedge sys_clk)
        $past(!rst_n) |-> (uv_pct == 8'h4B) && (pg_lo_pct == 8'h5A))
        else $error("undervoltage or power good default wrong");

    AST_OV_TURNOFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(qlvl[QU_OV]) |-> ##2 turn_off)
        else $error("turn-off not raised two cycles after qualified overvoltage");

    AST_OT_REARM: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(qlvl[QU_OT]) |-> ($past(temp_c, 2) <= $signed(`OT_REARM_C)))
        else $error("overtemperature released above the rearm level");

    AST_TRK_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        qcond[QU_TRK] |-> (trk_en && ramp_active))
        else $error("tracking check active outside an enabled ramp");

    AST_WARN_RISE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(ot_warning) |-> ($past(temp_c, 2) >= $signed(`WARN_C)))
        else $error("warning raised below its threshold");

    AST_WARN_FALL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(ot_warning) |-> ($past(temp_c, 2) <= $signed(`WARN_C - `WARN_HYST_C)))
        else $error("warning cleared inside its hysteresis");

    AST_PG_WINDOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(power_good_output) |-> (power_good_output == $past(in_window, 2)))
        else $error("power good changed against the window");

    AST_LATCH_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tripped[CH_OV] && latch_mode[CH_OV] && !clear_req[CH_OV]) |=> tripped[CH_OV])
        else $error("latched overvoltage released without a clear");

    AST_OC_TRIP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        oc_hit |=> tripped[CH_OC])
        else $error("overcurrent seen but channel not tripped");

    AST_OV_SPAN: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ov_pct >= 8'h6E) && (ov_pct <= 8'h82))
        else $error("overvoltage threshold outside its span");

    AST_UV_SPAN: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (uv_pct >= 8'h4B) && (uv_pct <= 8'h55))
        else $error("undervoltage threshold outside its span");

    AST_UV_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(qlvl[QU_UV]) |-> $past(output_on, 2) && !$past(ramp_active, 2))
        else $error("undervoltage qualified while the output was not regulating");

    AST_UV_TURNOFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(qlvl[QU_UV]) |-> ##2 turn_off)
        else $error("turn-off not raised after qualified undervoltage");

    AST_OT_TURNOFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(qlvl[QU_OT]) |-> ##2 turn_off)
        else $error("turn-off not raised after qualified overtemperature");

    AST_TRK_TURNOFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(qlvl[QU_TRK]) |-> ##2 turn_off)
        else $error("turn-off not raised after qualified tracking error");

    AST_TURNOFF_OR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        turn_off == $past(|tripped))
        else $error("turn-off does not follow the tripped channels");

    AST_OT_TRIP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(qlvl[QU_OT]) |-> ($past(temp_c, 2) >= $signed(`OT_TRIP_C)))
        else $error("overtemperature tripped below its threshold");

    AST_TRK_LIMIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(qlvl[QU_TRK]) |-> ($past(trk_err, 2) > `TRK_LIMIT_MV))
        else $error("tracking tripped inside its error band");

    AST_WARN_LEVEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(ot_warning) |-> (ot_warning == $past(qlvl[QU_WARN])))
        else $error("warning changed against its qualified level");

    AST_PG_SPAN: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (pg_lo_pct == 8'h5A) || (pg_lo_pct == 8'h5F))
        else $error("power good lower threshold outside its span");

    AST_PG_LEVEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(power_good_output) |-> (power_good_output == $past(qlvl[QU_PG])))
        else $error("power good changed against its qualified level");

    AST_RETRY_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tripped[CH_OT] && fault_set[CH_OT]) |=> tripped[CH_OT])
        else $error("overtemperature channel released while the fault stands");
endmodule : pol_fault_protection_monitor
`default_nettype wire

// *** rtl/pol_pkg.sv ***
package pol_pkg;
    typedef logic [12:0] millivolt_type;
    typedef logic [15:0] milliamp_type;
    typedef logic signed [9:0] celsius_type;
    // protections that can turn the output off
    typedef enum {CH_OC, CH_OV, CH_UV, CH_OT, CH_TRK, CH_COUNT} fault_ch_type;
    // conditions that pass through the 6 us qualifier
    typedef enum {QU_OV, QU_UV, QU_OT, QU_TRK, QU_WARN, QU_PG, QU_COUNT} qual_type;
endpackage : pol_pkg

// *** rtl/pol_regs.svh ***
`ifndef POL_REGS_SVH
`define POL_REGS_SVH

// register byte offsets
`define CTRL_ADDR 8'h00
`define SETPOINT_ADDR 8'h04
`define STATUS_ADDR 8'h08
`define CLEAR_ADDR 8'h0C

// control field positions
`define CTRL_OC_LSB 0
`define CTRL_OV_LSB 4
`define CTRL_UV_LSB 6
`define CTRL_PG_BIT 8
`define CTRL_LATCH_LSB 9
`define CTRL_TRK_BIT 14

// reset values
`define OC_CODE_RST 4'hA
`define OV_CODE_RST 2'h2
`define UV_CODE_RST 2'h0
`define PG_CODE_RST 1'h0
`define LATCH_RST 5'h00
`define TRK_EN_RST 1'h0
`define VSET_RST 13'h01F4

// threshold figures
`define OC_MAX_CODE 4'hA
`define OC_BASE_PCT 8'h3C
`define OC_STEP_PCT 8'h0B
`define OV_MAX_CODE 2'h2
`define OV_BASE_PCT 8'h6E
`define OV_STEP_PCT 8'h0A
`define OV_FLOOR_MV 13'h03E8
`define UV_MAX_CODE 2'h2
`define UV_BASE_PCT 8'h4B
`define UV_STEP_PCT 8'h05
`define PG_LO_BASE_PCT 8'h5A
`define PG_LO_STEP_PCT 8'h05
`define PG_HI_PCT 8'h6E
`define RATED_MA 32'h00003A98
`define OT_TRIP_C 10'h082
`define OT_REARM_C 10'h078
`define WARN_C 10'h078
`define WARN_HYST_C 10'h003
`define TRK_LIMIT_MV 14'h00FA

// timing
`define CLK_PERIOD_NS 100
`define FAULT_DELAY_NS 6000
`define FAULT_DELAY_CYC (`FAULT_DELAY_NS / `CLK_PERIOD_NS)
`define RETRY_PERIOD_MS 130
`define RETRY_CYC ((`RETRY_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// *** test/power_stage_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module power_stage_model (
    // clock and command from the monitor
    input wire logic sys_clk,
    input wire logic turn_off,
    // operating point asked for by the bench
    input wire logic [12:0] vout_set,
    input wire logic [15:0] iout_set,
    input wire logic [9:0] temp_set,
    // sensed quantities
    output pol_pkg::millivolt_type vout_mv,
    output pol_pkg::milliamp_type iout_ma,
    output pol_pkg::celsius_type temp_c,
    output logic output_on
);
    import pol_pkg::*;
    initial begin
        vout_mv = 13'h0000;
        iout_ma = 16'h0000;
        temp_c = 10'h019;
        output_on = 1'b1;
    end
    // a stage that is off discharges its output and carries no load current
    always @(posedge sys_clk) begin
        vout_mv <= turn_off ? 13'h0000 : vout_set;
        iout_ma <= turn_off ? 16'h0000 : iout_set;
        temp_c <= temp_set;
        output_on <= !turn_off;
    end
endmodule : power_stage_model

`default_nettype wire

// *** test/tb_pol_fault_protection_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_pol_fault_protection_monitor;
    import pol_pkg::*;
    localparam int RETRY = 200;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, output_on, turn_off, power_good_output, ot_warning;
    logic ramp_active = 1'b0;
    millivolt_type vout_mv, vref_mv;
    milliamp_type iout_ma;
    celsius_type temp_c;
    logic [12:0] vset = 13'h0000;
    logic [15:0] iset = 16'h0000;
    logic [9:0] tset = 10'h019;
    logic [31:0] q;
    int failures = 0;
    int n_compared = 0;
    int n;

    always #50 sys_clk = ~sys_clk;
    initial vref_mv = 13'h0000;

    pol_fault_protection_monitor #(.RETRY_CYCLES(RETRY)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .vout_mv(vout_mv),
        .vref_mv(vref_mv), .iout_ma(iout_ma), .temp_c(temp_c), .ramp_active(ramp_active),
        .output_on(output_on), .turn_off(turn_off),
        .power_good_output(power_good_output), .ot_warning(ot_warning));

    power_stage_model stage (
        .sys_clk(sys_clk), .turn_off(turn_off), .vout_set(vset), .iout_set(iset),
        .temp_set(tset), .vout_mv(vout_mv), .iout_ma(iout_ma), .temp_c(temp_c),
        .output_on(output_on));

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    // hreadyout is sampled at the edge itself, as a master would
    task automatic ready_wait();
        int k;
        k = 0;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1 && k < 50) begin
            @(posedge sys_clk);
            k++;
        end
        if (k == 50) begin
            check(1'b0, 1'b1, "bus stall");
            wrap_up();
        end
    endtask : ready_wait

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        ready_wait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        ready_wait();
        q = hrdata;
    endtask : bus

    // counts edges until an output shows val; 0 turn_off, 1 power good, 2 warning
    task automatic wait_for(input int which, input logic val, input int lim);
        logic s;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
            s = (which == 0) ? turn_off : (which == 1) ? power_good_output : ot_warning;
        end while (s !== val && n < lim);
        if (s !== val) begin
            check(s, val, "output wait ran out");
            wrap_up();
        end
    endtask : wait_for

    task automatic hold_check(input int cyc, input logic exp, input string msg);
        repeat (cyc) @(posedge sys_clk);
        #1;
        check(turn_off, exp, msg);
    endtask : hold_check

    task automatic s_reset();
        check({hreadyout, hresp, turn_off, power_good_output, ot_warning}, 5'h10, "reset out");
        bus(1'b0, 8'h00, 32'h0);
        check(q, 32'h0000002A, "ctrl defaults");
        bus(1'b1, 8'h00, 32'h000000FF);
        bus(1'b0, 8'h00, 32'h0);
        check(q, 32'h000000AA, "ctrl codes clamped");
        bus(1'b1, 8'h00, 32'h0000002A);
        bus(1'b0, 8'h04, 32'h0);
        check(q, 32'h000001F4, "setpoint default");
        bus(1'b0, 8'h10, 32'h0);
        check(q, 32'h00000000, "unmapped read");
    endtask : s_reset

    task automatic s_ov();
        @(posedge sys_clk);
        vset <= 13'd900;
        hold_check(100, 1'b0, "ov under one volt");
        @(posedge sys_clk);
        vset <= 13'd1100;
        wait_for(0, 1'b1, 200);
        check(n, 63, "ov delay");
        hold_check(150, 1'b1, "ov retry early");
        @(posedge sys_clk);
        vset <= 13'd600;
        wait_for(0, 1'b0, 400);
    endtask : s_ov

    task automatic s_pg();
        bus(1'b1, 8'h04, 32'd1000);
        @(posedge sys_clk);
        vset <= 13'd1000;
        wait_for(1, 1'b1, 200);
        check(n, 62, "pg rise delay");
        @(posedge sys_clk);
        vset <= 13'd1110;
        wait_for(1, 1'b0, 200);
        check(n, 62, "pg upper edge");
        @(posedge sys_clk);
        vset <= 13'd930;
        wait_for(1, 1'b1, 200);
        bus(1'b1, 8'h00, 32'h0000012A);
        wait_for(1, 1'b0, 200);
    endtask : s_pg

    task automatic s_uv();
        bus(1'b1, 8'h00, 32'h000008AA);
        @(posedge sys_clk);
        vset <= 13'd840;
        wait_for(0, 1'b1, 200);
        check(n, 63, "uv delay");
        hold_check(RETRY + 100, 1'b1, "uv latched");
        @(posedge sys_clk);
        vset <= 13'd1000;
        bus(1'b1, 8'h0C, 32'h00000004);
        wait_for(0, 1'b0, 10);
    endtask : s_uv

    task automatic s_oc();
        bus(1'b1, 8'h00, 32'h00000020);
        @(posedge sys_clk);
        iset <= 16'd8900;
        hold_check(80, 1'b0, "oc below 60 pct");
        @(posedge sys_clk);
        iset <= 16'd9100;
        wait_for(0, 1'b1, 20);
        check(n, 3, "oc trip");
        @(posedge sys_clk);
        iset <= 16'd0;
        wait_for(0, 1'b0, 400);
    endtask : s_oc

    task automatic s_ot();
        @(posedge sys_clk);
        tset <= 10'd121;
        wait_for(2, 1'b1, 200);
        check(n, 62, "warn delay");
        @(posedge sys_clk);
        tset <= 10'd130;
        wait_for(0, 1'b1, 200);
        check(n, 63, "ot delay");
        bus(1'b0, 8'h08, 32'h0);
        check(q, 32'h000034E8, "status during ot");
        @(posedge sys_clk);
        tset <= 10'd125;
        hold_check(RETRY + 100, 1'b1, "ot rearm early");
        @(posedge sys_clk);
        tset <= 10'd119;
        wait_for(0, 1'b0, 500);
        check(ot_warning, 1'b1, "warn hysteresis");
        @(posedge sys_clk);
        tset <= 10'd117;
        wait_for(2, 1'b0, 200);
        check(n, 62, "warn clear");
    endtask : s_ot

    task automatic s_trk();
        @(posedge sys_clk);
        ramp_active <= 1'b1;
        vref_mv <= 13'd500;
        vset <= 13'd800;
        hold_check(100, 1'b0, "tracking off by default");
        bus(1'b1, 8'h00, 32'h0000402A);
        wait_for(0, 1'b1, 200);
        @(posedge sys_clk);
        ramp_active <= 1'b0;
        wait_for(0, 1'b0, 400);
    endtask : s_trk

    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        s_reset();
        s_ov();
        s_pg();
        s_uv();
        s_oc();
        s_ot();
        s_trk();
        wrap_up();
    end
endmodule : tb_pol_fault_protection_monitor

`default_nettype wire
